// [rsw_defs.svh]
// constants for the reset, sleep and wake-up controller
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

// -----------------------------------------------------------------
// clock and timing (times in microseconds)
// -----------------------------------------------------------------
`define RSW_CLK_MHZ        20
`define RSW_RST_HOLD_US    18000
`define RSW_RST_LFX2_US    500000
`define RSW_WDT_PERIOD_US  18000
`define RSW_WAKE_RC_US     10
`define RSW_WAKE_XT_US     800
`define RSW_WAKE_LFX2_US   2000000
`define RSW_ADC_WAKE_TICKS 16

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define RSW_OFS_CTRL       4'h0
`define RSW_OFS_STATUS     4'h1
`define RSW_OFS_WDT_CTRL   4'h2
`define RSW_OFS_WAKE_EN    4'h3
`define RSW_OFS_IRQ_FLAG   4'h4
`define RSW_OFS_IRQ_MASK   4'h5
`define RSW_OFS_PCTL1      4'h6
`define RSW_OFS_PCTL2      4'h7
`define RSW_OFS_PCTL3      4'h8
`define RSW_OFS_DIR0       4'h9
`define RSW_OFS_DIR1       4'hA
`define RSW_OFS_DIR2       4'hB

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define RSW_CTRL_IDLE      2
`define RSW_ST_TFLAG       4
`define RSW_ST_PFLAG       3
`define RSW_ST_GIE         2
`define RSW_ST_SLEEP       0
`define RSW_WDT_EN         4
`define RSW_SRC_PCHG       1
`define RSW_SRC_ADC        2
`define RSW_SRC_LVD        3
`define RSW_WE_PCHG        1
`define RSW_WE_ADC         4
`define RSW_WE_LVD         5

// -----------------------------------------------------------------
// reset values and vectors
// -----------------------------------------------------------------
`define RSW_PCTL1_RST      8'hFF
`define RSW_PCTL2_RST      8'h00
`define RSW_PCTL3_RST      8'hFF
`define RSW_DIR_RST        8'hFF
`define RSW_WDT_KEEP_MASK  8'h4F
`define RSW_WE_KEEP_MASK   8'hCF
`define RSW_ST_KEEP_MASK   8'hE0
`define RSW_VEC_PCHG       12'h006
`define RSW_VEC_ADC        12'h00C
`define RSW_VEC_LVD        12'h021
`define RSW_OSC_LFX2       2'h2
`define RSW_OSC_XT         2'h1

`endif

// [rsw_pkg.sv]
// types shared by the reset, sleep and wake-up controller
package rsw_pkg;

  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_HOLD  = 4'h2,
    ST_SLEEP = 4'h4,
    ST_WAKE  = 4'h8
  } rsw_state_t;

  typedef struct packed {
    logic lvd;
    logic adc;
    logic pchg;
  } rsw_src_t;

endpackage

// [rsw_ctrl.sv]
// reset, sleep and wake-up controller for the cpu core
// -----------------------------------------------------------------
// -----------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "rsw_defs.svh"

module rsw_ctrl #(
  parameter int unsigned HOLD_CYC  = `RSW_RST_HOLD_US * `RSW_CLK_MHZ,
  parameter int unsigned LFX2_CYC  = `RSW_RST_LFX2_US * `RSW_CLK_MHZ,
  parameter int unsigned WDT_CYC   = `RSW_WDT_PERIOD_US * `RSW_CLK_MHZ,
  parameter int unsigned WAKE_RC   = `RSW_WAKE_RC_US * `RSW_CLK_MHZ,
  parameter int unsigned WAKE_XT   = `RSW_WAKE_XT_US * `RSW_CLK_MHZ,
  parameter int unsigned WAKE_LFX2 = `RSW_WAKE_LFX2_US * `RSW_CLK_MHZ,
  parameter int unsigned PC_W      = 12
) (
  // clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_rst_n,
  // register port
  input  wire logic [3:0]      i_addr,
  input  wire logic [7:0]      i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [7:0]      o_rdata,
  // pins
  input  wire logic            i_rst_pin_n,
  input  wire logic [7:0]      i_port5,
  input  wire logic            i_lvd,
  // cpu core and adc
  input  wire logic            i_sleep_instr,
  input  wire logic            i_wdt_clr_instr,
  input  wire logic            i_gie_set,
  input  wire logic            i_gie_clr,
  input  wire logic            i_port5_read,
  input  wire logic            i_adc_busy,
  input  wire logic            i_adc_done,
  input  wire logic            i_adc_tick,
  // control outputs
  output logic                 o_core_rst,
  output logic                 o_pc_load,
  output logic      [PC_W-1:0] o_pc_value,
  output logic                 o_resume,
  output logic                 o_osc_en,
  output logic                 o_timers_en,
  output logic                 o_irq_req,
  output logic      [23:0]     o_port_dir,
  output logic      [7:0]      o_pctl1,
  output logic      [7:0]      o_pctl2,
  output logic      [7:0]      o_pctl3
);

  // -----------------------------------------------------------------
  // elaboration checks
  // -----------------------------------------------------------------
  if (HOLD_CYC < 1 || LFX2_CYC < 1 || WDT_CYC < 1 || WAKE_RC < 1 ||
      WAKE_XT < 1 || WAKE_LFX2 < 1 || PC_W < 6) begin : g_chk
    $error("rsw_ctrl: counts must be at least one, PC_W at least 6");
  end

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [9:0] sync1_reg;
  logic [9:0] sync2_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_reg <= 10'h200;
      sync2_reg <= 10'h200;
    end else begin
      sync1_reg <= {i_rst_pin_n, i_port5, i_lvd};
      sync2_reg <= sync1_reg;
    end
  end
  wire       pin_n_s = sync2_reg[9];
  wire [7:0] port5_s = sync2_reg[8:1];
  wire       lvd_s   = sync2_reg[0];

  // -----------------------------------------------------------------
  // registers and state
  // -----------------------------------------------------------------
  rsw_pkg::rsw_state_t state_reg;
  rsw_pkg::rsw_state_t state_next;
  rsw_pkg::rsw_src_t   wake_src_reg;
  logic [31:0] cnt_reg;
  logic [31:0] wdt_base_reg;
  logic [7:0]  wdt_psc_reg;
  logic [7:0]  ctrl_reg;
  logic [7:0]  status_reg;
  logic [7:0]  wdt_ctrl_reg;
  logic [7:0]  wake_en_reg;
  logic [7:0]  flag_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  port5_last_reg;
  logic        gie_reg;
  logic        lvd_d_reg;
  logic        idle_reg;

  // -----------------------------------------------------------------
  // event decode
  // -----------------------------------------------------------------
  wire wdt_en   = wdt_ctrl_reg[`RSW_WDT_EN];
  wire wdt_wrap = wdt_base_reg == 32'(WDT_CYC - 1);
  wire [7:0] psc_ratio = 8'h1 << wdt_ctrl_reg[2:0];
  wire wdt_to   = wdt_en && wdt_wrap &&
                  (wdt_psc_reg == psc_ratio - 8'h1);
  wire pchg_evt = |(port5_s ^ port5_last_reg);
  wire lvd_evt  = lvd_s && !lvd_d_reg;
  wire [7:0] evt_vec = {4'h0, lvd_evt, i_adc_done, pchg_evt, 1'b0};
  wire in_sleep = state_reg == rsw_pkg::ST_SLEEP;
  wire in_hold  = state_reg == rsw_pkg::ST_HOLD;
  wire in_run   = state_reg == rsw_pkg::ST_RUN;
  wire [2:0] wake_hit = {lvd_evt  && wake_en_reg[`RSW_WE_LVD],
                         i_adc_done && wake_en_reg[`RSW_WE_ADC],
                         pchg_evt && wake_en_reg[`RSW_WE_PCHG]};
  wire go_rst    = !pin_n_s || wdt_to;
  wire rst_start = go_rst && !in_hold;
  wire sleep_go  = in_run && i_sleep_instr && !go_rst;
  wire keep_osc  = ctrl_reg[`RSW_CTRL_IDLE] || i_adc_busy;
  wire is_lfx2   = ctrl_reg[1:0] == `RSW_OSC_LFX2;
  wire [31:0] hold_len = is_lfx2 ? 32'(LFX2_CYC) : 32'(HOLD_CYC);
  wire hold_done = in_hold && pin_n_s &&
                   (cnt_reg >= hold_len - 32'h1);
  // oscillator-mode wake latency; idle keeps the clock so one cycle
  wire [31:0] osc_lat = idle_reg ? 32'h1 :
                        is_lfx2 ? 32'(WAKE_LFX2) :
                        (ctrl_reg[1:0] == `RSW_OSC_XT) ? 32'(WAKE_XT) :
                        32'(WAKE_RC);
  wire wake_done = (state_reg == rsw_pkg::ST_WAKE) &&
                   (wake_src_reg.adc ?
                    (i_adc_tick &&
                     cnt_reg == 32'(`RSW_ADC_WAKE_TICKS - 1)) :
                    (cnt_reg >= osc_lat - 32'h1));
  wire [7:0] src_irq = mask_reg & {4'h0, wake_src_reg.lvd,
                       wake_src_reg.adc, wake_src_reg.pchg, 1'b0};
  wire take_vec  = gie_reg && |src_irq;
  wire [11:0] vec_sel = wake_src_reg.pchg ? `RSW_VEC_PCHG :
                        wake_src_reg.adc  ? `RSW_VEC_ADC :
                        `RSW_VEC_LVD;
  wire wr_ok = i_wr && !in_hold;

  // -----------------------------------------------------------------
  // state machine
  // -----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rsw_pkg::ST_HOLD:
        if (hold_done) state_next = rsw_pkg::ST_RUN;
      rsw_pkg::ST_RUN:
        if (go_rst) state_next = rsw_pkg::ST_HOLD;
        else if (i_sleep_instr) state_next = rsw_pkg::ST_SLEEP;
      rsw_pkg::ST_SLEEP:
        if (go_rst) state_next = rsw_pkg::ST_HOLD;
        else if (|wake_hit) state_next = rsw_pkg::ST_WAKE;
      rsw_pkg::ST_WAKE:
        if (go_rst) state_next = rsw_pkg::ST_HOLD;
        else if (wake_done) state_next = rsw_pkg::ST_RUN;
      default:
        state_next = rsw_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg    <= rsw_pkg::ST_HOLD;
      cnt_reg      <= 32'h0;
      wake_src_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= 32'h0;
      end else if (!wake_src_reg.adc || in_hold || i_adc_tick) begin
        cnt_reg <= cnt_reg + 32'h1;
      end
      if (in_sleep && |wake_hit) begin
        // one enabled source is expected; lowest bit wins otherwise
        wake_src_reg <= wake_hit[0] ? 3'h1 :
                        wake_hit[1] ? 3'h2 : 3'h4;
      end
    end
  end

  // -----------------------------------------------------------------
  // core, clock and pc outputs
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_rst   <= 1'b1;
      o_pc_load    <= 1'b0;
      o_pc_value   <= '0;
      o_resume     <= 1'b0;
      o_osc_en     <= 1'b1;
      o_timers_en  <= 1'b1;
      idle_reg     <= 1'b0;
    end else begin
      o_core_rst <= state_next == rsw_pkg::ST_HOLD;
      o_pc_load  <= 1'b0;
      o_resume   <= 1'b0;
      if (hold_done) begin
        o_pc_load  <= 1'b1;
        o_pc_value <= '0;
      end else if (wake_done && !go_rst) begin
        o_pc_load  <= take_vec;
        o_resume   <= !take_vec;
        o_pc_value <= PC_W'(vec_sel);
      end
      if (sleep_go) begin
        idle_reg     <= ctrl_reg[`RSW_CTRL_IDLE];
        o_osc_en     <= keep_osc;
        o_timers_en  <= keep_osc;
      end else if (go_rst || state_next == rsw_pkg::ST_RUN) begin
        o_osc_en    <= 1'b1;
        o_timers_en <= 1'b1;
      end else if (state_next == rsw_pkg::ST_WAKE) begin
        o_osc_en <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // watchdog counter and prescaler
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wdt_base_reg <= 32'h0;
      wdt_psc_reg  <= 8'h0;
    end else if (go_rst || in_hold || sleep_go || i_wdt_clr_instr) begin
      wdt_base_reg <= 32'h0;
      wdt_psc_reg  <= 8'h0;
    end else if (wdt_wrap) begin
      wdt_base_reg <= 32'h0;
      wdt_psc_reg  <= (wdt_psc_reg == psc_ratio - 8'h1) ?
                      8'h0 : wdt_psc_reg + 8'h1;
    end else begin
      wdt_base_reg <= wdt_base_reg + 32'h1;
    end
  end

  // -----------------------------------------------------------------
  // software registers
  // -----------------------------------------------------------------
  wire [3:0] a = i_addr;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_reg       <= 8'h0;
      status_reg     <= 8'h0;
      wdt_ctrl_reg   <= 8'h0;
      wake_en_reg    <= 8'h0;
      mask_reg       <= 8'h0;
      o_pctl1        <= `RSW_PCTL1_RST;
      o_pctl2        <= `RSW_PCTL2_RST;
      o_pctl3        <= `RSW_PCTL3_RST;
      o_port_dir     <= {3{`RSW_DIR_RST}};
      gie_reg        <= 1'b0;
    end else if (rst_start) begin
      // status upper bits survive a pin or watchdog reset
      status_reg <= (status_reg & `RSW_ST_KEEP_MASK) |
                    {3'h0, wdt_to, in_sleep, 3'h0};
      wdt_ctrl_reg <= wdt_ctrl_reg & `RSW_WDT_KEEP_MASK;
      wake_en_reg  <= wake_en_reg & `RSW_WE_KEEP_MASK;
      mask_reg     <= 8'h0;
      o_pctl1      <= `RSW_PCTL1_RST;
      o_pctl2      <= `RSW_PCTL2_RST;
      o_pctl3      <= `RSW_PCTL3_RST;
      o_port_dir   <= {3{`RSW_DIR_RST}};
      gie_reg      <= 1'b0;
    end else begin
      if (i_gie_set) gie_reg <= 1'b1;
      else if (i_gie_clr) gie_reg <= 1'b0;
      if (wr_ok) begin
        case (a)
          `RSW_OFS_CTRL:     ctrl_reg <= i_wdata;
          `RSW_OFS_STATUS:
            status_reg <= {i_wdata[7:5], status_reg[4:0]};
          `RSW_OFS_WDT_CTRL: wdt_ctrl_reg <= i_wdata;
          `RSW_OFS_WAKE_EN:  wake_en_reg <= i_wdata;
          `RSW_OFS_IRQ_MASK: mask_reg <= i_wdata;
          `RSW_OFS_PCTL1:    o_pctl1 <= i_wdata;
          `RSW_OFS_PCTL2:    o_pctl2 <= i_wdata;
          `RSW_OFS_PCTL3:    o_pctl3 <= i_wdata;
          `RSW_OFS_DIR0:     o_port_dir[7:0] <= i_wdata;
          `RSW_OFS_DIR1:     o_port_dir[15:8] <= i_wdata;
          `RSW_OFS_DIR2:     o_port_dir[23:16] <= i_wdata;
          default: ;
        endcase
      end
    end
  end

  // flags: a hardware set beats a software clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_reg       <= 8'h0;
      port5_last_reg <= 8'h0;
      lvd_d_reg      <= 1'b0;
      o_irq_req      <= 1'b0;
    end else begin
      lvd_d_reg <= lvd_s;
      if (i_port5_read || in_hold) port5_last_reg <= port5_s;
      if (go_rst || in_hold) begin
        flag_reg <= 8'h0;
      end else if (wr_ok && a == `RSW_OFS_IRQ_FLAG) begin
        flag_reg <= i_wdata | evt_vec;
      end else begin
        flag_reg <= flag_reg | evt_vec;
      end
      o_irq_req <= in_run && gie_reg && |(flag_reg & mask_reg);
    end
  end

  // -----------------------------------------------------------------
  // read port
  // -----------------------------------------------------------------
  wire [7:0] status_rd = {status_reg[7:3], gie_reg, 1'b0, in_sleep};
  wire [7:0] rd_mux =
    (a == `RSW_OFS_CTRL)     ? ctrl_reg :
    (a == `RSW_OFS_STATUS)   ? status_rd :
    (a == `RSW_OFS_WDT_CTRL) ? wdt_ctrl_reg :
    (a == `RSW_OFS_WAKE_EN)  ? wake_en_reg :
    (a == `RSW_OFS_IRQ_FLAG) ? flag_reg :
    (a == `RSW_OFS_IRQ_MASK) ? mask_reg :
    (a == `RSW_OFS_PCTL1)    ? o_pctl1 :
    (a == `RSW_OFS_PCTL2)    ? o_pctl2 :
    (a == `RSW_OFS_PCTL3)    ? o_pctl3 :
    (a == `RSW_OFS_DIR0)     ? o_port_dir[7:0] :
    (a == `RSW_OFS_DIR1)     ? o_port_dir[15:8] :
    (a == `RSW_OFS_DIR2)     ? o_port_dir[23:16] : 8'h00;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_rdata <= 8'h0;
    else o_rdata <= i_rd ? rd_mux : 8'h0;
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  a_reset_cause: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (in_run && !pin_n_s) |=> in_hold && o_core_rst)
    else $error("pin reset did not enter hold");
  a_hold_length: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (in_hold && cnt_reg == 32'h0 && pin_n_s && !is_lfx2 &&
     HOLD_CYC > 2) |=> in_hold)
    else $error("reset hold ended too early");
  a_pc_zero: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    hold_done |=> o_pc_load && o_pc_value == '0 && !o_core_rst)
    else $error("reset exit did not load address zero");
  a_port_input: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rst_start |=> o_port_dir == 24'hFFFFFF && o_osc_en)
    else $error("reset left a pin output or clock off");
  a_wdt_cleared: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (rst_start || sleep_go) |=> wdt_base_reg == 32'h0 &&
    wdt_psc_reg == 8'h0)
    else $error("watchdog not cleared");
  a_status_kept: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rst_start |=> status_reg[7:5] == $past(status_reg[7:5]))
    else $error("status upper bits changed on warm reset");
  a_pctl_values: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    rst_start |=> o_pctl1 == 8'hFF && o_pctl2 == 8'h00 &&
    o_pctl3 == 8'hFF && mask_reg == 8'h0)
    else $error("port control reset values wrong");
  a_sleep_clocks: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    sleep_go |=> o_osc_en == $past(keep_osc) && in_sleep)
    else $error("sleep entry clock state wrong");
  a_no_wake: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (in_sleep && wake_hit == 3'h0 && !go_rst) |=> in_sleep)
    else $error("woke without an enabled source");
  a_wake_vector: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (wake_done && !go_rst && take_vec) |=>
    o_pc_load && !o_resume && in_run)
    else $error("enabled wake did not take its vector");

endmodule
`default_nettype wire

// [rsw_adc_model.sv]
// behavioural adc partner: conversion busy, done pulse and adc clock
`timescale 1ns/100ps
`default_nettype none

module rsw_adc_model (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // conversion request
  input  wire logic i_start,
  // adc status
  output logic      o_busy,
  output logic      o_done,
  output logic      o_tick
);
  logic [3:0] cnt_reg;
  logic       tick_reg;

  // adc clock runs at half the core clock, conversion lasts 9 cycles
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= ~tick_reg;
      if (i_start) cnt_reg <= 4'hA;
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end
  end

  assign o_busy = (cnt_reg > 4'h1);
  assign o_done = (cnt_reg == 4'h1);
  assign o_tick = tick_reg;
endmodule
`default_nettype wire

// [rsw_ctrl_tb.sv]
// self-checking bench for the reset, sleep and wake-up controller
`timescale 1ns/100ps
`default_nettype none
`include "rsw_defs.svh"

module rsw_ctrl_tb;
  // -----------------------------------------------------------------
  // stimulus and observed signals
  // -----------------------------------------------------------------
  logic        i_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00, i_port5 = 8'h00, o_rdata, o_pctl1;
  logic        i_rst_pin_n = 1'b1, i_lvd = 1'b0;
  logic        sleep_in = 1'b0, gie_set = 1'b0, gie_clr = 1'b0;
  logic        p5_rd = 1'b0, wdt_clr = 1'b0, adc_start = 1'b0;
  logic        adc_busy, adc_done, adc_tick, o_core_rst, o_pc_load;
  logic        o_resume, o_osc_en, o_timers_en, o_irq_req;
  logic [11:0] o_pc_value;
  logic [23:0] o_port_dir;
  logic [7:0]  o_pctl2, o_pctl3;
  int          err_count = 0, check_count = 0;

  always #25 i_clk = ~i_clk;

  rsw_ctrl #(.HOLD_CYC(20), .LFX2_CYC(40), .WDT_CYC(50), .WAKE_RC(4),
    .WAKE_XT(8), .WAKE_LFX2(30)) u_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rst_pin_n(i_rst_pin_n), .i_port5(i_port5), .i_lvd(i_lvd),
    .i_sleep_instr(sleep_in), .i_gie_set(gie_set), .i_gie_clr(gie_clr),
    .i_port5_read(p5_rd), .i_wdt_clr_instr(wdt_clr),
    .i_adc_busy(adc_busy), .i_adc_done(adc_done), .i_adc_tick(adc_tick),
    .o_core_rst(o_core_rst), .o_pc_load(o_pc_load),
    .o_pc_value(o_pc_value), .o_resume(o_resume), .o_osc_en(o_osc_en),
    .o_timers_en(o_timers_en), .o_irq_req(o_irq_req),
    .o_port_dir(o_port_dir),
    .o_pctl1(o_pctl1), .o_pctl2(o_pctl2), .o_pctl3(o_pctl3));

  rsw_adc_model u_adc (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(adc_start),
    .o_busy(adc_busy), .o_done(adc_done), .o_tick(adc_tick));

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask

  // bit 0 sleep, 1 gie set, 2 gie clear, 3 port read, 4 wdt clear, 5 adc
  task pulse(input logic [5:0] m);
    @(posedge i_clk);
    {adc_start, wdt_clr, p5_rd, gie_clr, gie_set, sleep_in} <= m;
    @(posedge i_clk);
    {adc_start, wdt_clr, p5_rd, gie_clr, gie_set, sleep_in} <= 6'h00;
  endtask

  task wait_rst(input logic lvl, input int lim, output int n);
    n = 0;
    while (o_core_rst !== lvl && n < lim) begin
      @(posedge i_clk); #1 n++;
    end
  endtask

  task wait_out(input int lim, output int n);
    n = 0;
    while (o_pc_load !== 1'b1 && o_resume !== 1'b1 && n < lim) begin
      @(posedge i_clk); #1 n++;
    end
  endtask

  task go_sleep(input logic [5:0] m);
    pulse(m);
    pulse(6'h01);
    @(posedge i_clk); #1;
  endtask

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_por;
    int n; logic [7:0] v;
    chk(o_core_rst, 1);
    chk(o_osc_en, 1);
    chk(o_port_dir, 24'hFFFFFF);
    chk({o_pctl1, o_pctl2, o_pctl3}, 24'hFF00FF);
    wait_rst(1'b0, 200, n);
    chk(24'(n >= 18 && n < 30), 1);
    chk({o_pc_load, o_pc_value}, 13'h1000);
    rd(`RSW_OFS_STATUS, v); chk(v, 8'h00);
    rd(`RSW_OFS_IRQ_FLAG, v); chk(v, 8'h00);
    rd(`RSW_OFS_IRQ_MASK, v); chk(v, 8'h00);
    $display("test power-on reset done");
  endtask

  task t_wdt;
    int n; logic [7:0] v;
    wr(`RSW_OFS_STATUS, 8'hE0); wr(`RSW_OFS_DIR0, 8'h00);
    wr(`RSW_OFS_PCTL2, 8'h5A);
    wr(`RSW_OFS_WDT_CTRL, 8'h10);
    repeat (26) @(posedge i_clk);
    pulse(6'h10);
    wait_rst(1'b1, 200, n);
    chk(24'(n >= 49 && n <= 51), 1);
    wait_rst(1'b0, 200, n);
    chk(o_port_dir, 24'hFFFFFF);
    chk(o_pctl2, 8'h00);
    rd(`RSW_OFS_STATUS, v); chk(v[7:3], 5'h1E);
    rd(`RSW_OFS_WDT_CTRL, v); chk(v, 8'h00);
    $display("test watchdog reset done");
  endtask

  task t_pchg;
    int n;
    wr(`RSW_OFS_CTRL, 8'h01);
    wr(`RSW_OFS_WAKE_EN, 8'h02); wr(`RSW_OFS_IRQ_MASK, 8'h02);
    go_sleep(6'h0A);
    chk({o_osc_en, o_timers_en}, 0);
    @(posedge i_clk) i_port5 <= 8'h10;
    wait_out(100, n);
    chk(24'(n >= 10 && n <= 12), 1);
    chk({o_pc_load, o_pc_value}, 13'h1006);
    @(posedge i_clk); #1;
    chk(o_irq_req, 1);
    $display("test port change wake done");
  endtask

  task t_adc;
    int n;
    wr(`RSW_OFS_IRQ_FLAG, 8'h00); wr(`RSW_OFS_IRQ_MASK, 8'h04);
    wr(`RSW_OFS_WAKE_EN, 8'h10);
    go_sleep(6'h2A);
    chk(o_osc_en, 1);
    wait_out(100, n);
    chk(24'(n >= 36 && n <= 40), 1);
    chk({o_pc_load, o_pc_value}, 13'h100C);
    $display("test adc wake done");
  endtask

  task t_lvd_idle;
    int n;
    wr(`RSW_OFS_CTRL, 8'h04); wr(`RSW_OFS_IRQ_FLAG, 8'h00);
    wr(`RSW_OFS_IRQ_MASK, 8'h08); wr(`RSW_OFS_WAKE_EN, 8'h20);
    go_sleep(6'h0C);
    chk(o_osc_en, 1);
    @(posedge i_clk) i_lvd <= 1'b1;
    wait_out(100, n);
    chk({o_resume, o_pc_load}, 2'h2);
    wr(`RSW_OFS_CTRL, 8'h00);
    $display("test low voltage idle wake done");
  endtask

  task t_nowake;
    int n; logic [7:0] v;
    wr(`RSW_OFS_WAKE_EN, 8'h00); wr(`RSW_OFS_IRQ_MASK, 8'h00);
    wr(`RSW_OFS_CTRL, 8'h02);
    go_sleep(6'h08);
    @(posedge i_clk) i_port5 <= 8'h33;
    wait_out(60, n);
    chk(24'(n), 60);
    @(posedge i_clk) i_rst_pin_n <= 1'b0;
    wait_rst(1'b1, 20, n);
    chk(o_core_rst, 1);
    chk(o_osc_en, 1);
    @(posedge i_clk) i_rst_pin_n <= 1'b1;
    wait_rst(1'b0, 200, n);
    chk(24'(n >= 37 && n <= 41), 1);
    rd(`RSW_OFS_STATUS, v); chk(v[3], 1);
    $display("test no wake and pin reset done");
  endtask

  // -----------------------------------------------------------------
  // run control
  // -----------------------------------------------------------------
  task conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    err_count++;
    conclude;
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk); #1;
    t_por;
    t_wdt;
    t_pchg;
    t_adc;
    t_lvd_idle;
    t_nowake;
    conclude;
  end
endmodule
`default_nettype wire
